// ### src/pasc_ctrl.sv
// Purpose: positive alarm sequence controller for per-zone notification
// Assumes: all field inputs are asynchronous levels; acknowledge and panel
//   reset are levels treated on their rising edge
// Notes: one sequence runs at a time; the first detector alarm owns it
`timescale 1ns/10ps
`default_nettype none
module pasc_ctrl
  import pasc_pkg::*;
#(
  parameter int ZONES = 8,
  parameter int unsigned ACK_CNT = ACK_CYCLES,
  parameter int unsigned INV_CNT = INVESTIGATE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic sequence_enable,
  // field inputs; detector and other initiating vectors carry one bit per zone
  input wire logic [ZONES-1:0] detector_alarm,
  input wire logic [ZONES-1:0] other_initiating,
  input wire logic acknowledge,
  input wire logic panel_reset,
  input wire logic sequence_bypass_input,
  // outputs
  output logic [ZONES-1:0] zone_notify,
  output pasc_pkg::pasc_annunc_t annunc,
  output pasc_pkg::pasc_state_t state
);
  import pasc_pkg::*;

  // refused at elaboration: the logic cannot serve these values
  if (ZONES < 1 || ZONES > 32 || ACK_CNT < 1 || INV_CNT < 1) begin : g_bad
    $error("pasc_ctrl: unsupported parameter value");
  end

  // ****************************************************
  // input synchronisation
  // ****************************************************
  localparam int SW = 2 * ZONES + 4;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  assign raw = {detector_alarm, other_initiating, acknowledge, panel_reset,
                sequence_bypass_input, sequence_enable};

  pasc_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(raw),
    .dout(syn)
  );

  logic [ZONES-1:0] det_s;
  logic [ZONES-1:0] oth_s;
  logic ack_s;
  logic rst_s;
  logic byp_s;
  logic en_s;
  assign det_s = syn[SW-1 -: ZONES];
  assign oth_s = syn[ZONES+3 -: ZONES];
  assign ack_s = syn[3];
  assign rst_s = syn[2];
  assign byp_s = syn[1];
  assign en_s = syn[0];

  // lowest set bit as one-hot, used for picking the owning zone
  function automatic logic [ZONES-1:0] first_one(input logic [ZONES-1:0] v);
    first_one = v & (~v + 1'b1);
  endfunction : first_one

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    pasc_state_t fsm;
    logic [TMR_W-1:0] tmr;
    logic [ZONES-1:0] owner;
    logic [ZONES-1:0] det_prev;
    logic ack_prev;
    logic rst_prev;
    logic [ZONES-1:0] notify;
    pasc_annunc_t ann;
  } pasc_st_t;
  pasc_st_t st_q;
  pasc_st_t st_d;

  logic active;
  logic ack_rise;
  logic rst_rise;
  logic [ZONES-1:0] det_new;
  logic [ZONES-1:0] other_det;
  assign active = en_s && !byp_s;
  assign ack_rise = ack_s && !st_q.ack_prev;
  assign rst_rise = rst_s && !st_q.rst_prev;
  assign det_new = det_s & ~st_q.det_prev;
  assign other_det = det_s & ~st_q.owner;

  always_comb begin
    st_d = st_q;
    st_d.det_prev = det_s;
    st_d.ack_prev = ack_s;
    st_d.rst_prev = rst_s;
    st_d.ann.trouble = byp_s;
    if (rst_rise) begin
      // panel reset wins over every pending event
      st_d.fsm = PASC_IDLE;
      st_d.tmr = '0;
      st_d.owner = '0;
      st_d.notify = '0;
      st_d.ann.buzzer = 1'b0;
      st_d.ann.display_msg = 1'b0;
    end else begin
      // bypassed or disabled: detectors go straight to notification
      if (!active) begin
        st_d.notify = st_q.notify | det_s;
      end
      st_d.notify = st_d.notify | oth_s;
      unique case (st_q.fsm)
        PASC_IDLE: begin
          if (active && |det_new) begin
            st_d.owner = first_one(det_new);
            st_d.tmr = '0;
            st_d.ann.buzzer = 1'b1;
            st_d.ann.display_msg = 1'b1;
            // panel already sounding: a fresh alarm gets no grace period
            if (|oth_s || |st_q.notify) begin
              st_d.fsm = PASC_NOTIFY;
              st_d.notify = st_d.notify | first_one(det_new);
            end else begin
              st_d.fsm = PASC_WAIT_ACK;
            end
          end
        end
        PASC_WAIT_ACK: begin
          st_d.tmr = st_q.tmr + 1'b1;
          if (|oth_s || |other_det || !active) begin
            st_d.fsm = PASC_NOTIFY;
            st_d.notify = st_d.notify | st_q.owner;
          end else if (ack_rise) begin
            st_d.fsm = PASC_INVESTIGATE;
            st_d.tmr = '0;
          end else if (st_q.tmr >= TMR_W'(ACK_CNT - 1)) begin
            st_d.fsm = PASC_NOTIFY;
            st_d.notify = st_d.notify | st_q.owner;
          end
        end
        PASC_INVESTIGATE: begin
          st_d.tmr = st_q.tmr + 1'b1;
          if (|oth_s || |other_det || !active) begin
            st_d.fsm = PASC_NOTIFY;
            st_d.notify = st_d.notify | st_q.owner;
          end else if (st_q.tmr >= TMR_W'(INV_CNT - 1)) begin
            st_d.fsm = PASC_NOTIFY;
            st_d.notify = st_d.notify | st_q.owner;
          end
        end
        PASC_NOTIFY: begin
          st_d.tmr = '0;
          st_d.notify = st_d.notify | st_q.owner;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{fsm: PASC_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign zone_notify = st_q.notify;
  assign annunc = st_q.ann;
  assign state = st_q.fsm;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ack_wait;
    st_q.fsm == PASC_WAIT_ACK;
  endsequence

  chk_wait_quiet: assert property (
    s_ack_wait |-> (st_q.notify & st_q.owner) == '0 && st_q.ann.buzzer)
    else $error("zone notify active before acknowledge");
  chk_ack_starts: assert property (
    s_ack_wait and (ack_rise && active && !rst_rise && oth_s == '0
      && other_det == '0) |=> st_q.fsm == PASC_INVESTIGATE)
    else $error("acknowledge did not start investigation");
  chk_ack_timeout: assert property (
    s_ack_wait and (st_q.tmr == TMR_W'(ACK_CNT - 1) && !rst_rise
      && !ack_rise) |=> (st_q.notify & $past(st_q.owner)) != '0)
    else $error("missing notify after acknowledge timeout");
  chk_inv_expire: assert property (
    st_q.fsm == PASC_INVESTIGATE && st_q.tmr == TMR_W'(INV_CNT - 1)
      && !rst_rise |=> st_q.fsm == PASC_NOTIFY)
    else $error("investigation did not expire on time");
  chk_inv_bound: assert property (
    st_q.fsm == PASC_INVESTIGATE |-> st_q.tmr < TMR_W'(INV_CNT))
    else $error("investigation timer overran");
  chk_reset_idle: assert property (
    rst_rise |=> st_q.fsm == PASC_IDLE && st_q.notify == '0)
    else $error("panel reset did not return to idle");
  chk_second_dev: assert property (
    st_q.fsm == PASC_INVESTIGATE && oth_s != '0 && !rst_rise
      |=> st_q.fsm == PASC_NOTIFY)
    else $error("second device did not notify");
  chk_second_det: assert property (
    st_q.fsm == PASC_INVESTIGATE && other_det != '0 && !rst_rise
      |=> (st_q.notify & $past(st_q.owner)) != '0)
    else $error("second detector did not notify");
  chk_bypass_trbl: assert property (
    byp_s |=> st_q.ann.trouble)
    else $error("bypass without trouble");
  chk_bypass_clr: assert property (
    !byp_s |=> !st_q.ann.trouble)
    else $error("trouble stuck after bypass release");
  chk_global_off: assert property (
    !en_s && (det_s != '0) && !rst_rise |=> (st_q.notify & $past(det_s)) != '0)
    else $error("disabled sequence delayed notification");
endmodule : pasc_ctrl
`default_nettype wire

// ### common/pasc_pkg.sv
// Purpose: constants and types for the positive alarm sequence controller
// Assumes: 10 MHz system clock, one panel reset pulse input
// Notes: zone count is a module parameter; timing counts derive from clock
package pasc_pkg;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ACK_WINDOW_S = 15;
  localparam int unsigned INVESTIGATE_S = 180;
  // longest time fits TMR_W bits; whole seconds divide exactly
  localparam int unsigned ACK_CYCLES = ACK_WINDOW_S * CLK_HZ;
  localparam int unsigned INVESTIGATE_CYCLES = INVESTIGATE_S * CLK_HZ;
  localparam int unsigned TMR_W = 32;

  // ****************************************************
  // states and carriers
  // ****************************************************
  typedef enum logic [1:0] {
    PASC_IDLE,
    PASC_WAIT_ACK,
    PASC_INVESTIGATE,
    PASC_NOTIFY
  } pasc_state_t;

  typedef struct packed {
    logic buzzer;
    logic display_msg;
    logic trouble;
  } pasc_annunc_t;
endpackage : pasc_pkg

// ### src/pasc_sync.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pasc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (W < 1) begin : g_bad_w
    $error("pasc_sync: width below one");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pasc_sync_st_t;
  pasc_sync_st_t st_q;
  pasc_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule : pasc_sync
`default_nettype wire

// ### test/pasc_field_model.sv
// Purpose: field side of the controller: detectors, stations, keypad
// Assumes: every change lands on a falling clock edge
// Notes: pulses last 3 cycles so the 2-flop synchroniser sees each one
`timescale 1ns/10ps
`default_nettype none
module pasc_field_model #(
  parameter int ZONES = 4
) (
  // clock
  input wire logic clk,
  // field drive
  output logic sequence_enable,
  output logic [ZONES-1:0] detector_alarm,
  output logic [ZONES-1:0] other_initiating,
  output logic acknowledge,
  output logic panel_reset,
  output logic sequence_bypass_input
);
  initial begin
    sequence_enable = 1'h1;
    detector_alarm = '0;
    other_initiating = '0;
    acknowledge = 1'h0;
    panel_reset = 1'h0;
    sequence_bypass_input = 1'h0;
  end
  // all field levels are driven from here, never from outside
  task automatic set_det(input int z, input logic v);
    detector_alarm[z] = v;
  endtask : set_det
  task automatic set_oth(input int z, input logic v);
    other_initiating[z] = v;
  endtask : set_oth
  task automatic set_bypass(input logic v);
    sequence_bypass_input = v;
  endtask : set_bypass
  task automatic set_enable(input logic v);
    sequence_enable = v;
  endtask : set_enable
  task automatic clear_field;
    detector_alarm = '0;
    other_initiating = '0;
  endtask : clear_field
  // which 0 is the keypad acknowledge, anything else the panel reset
  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 0) acknowledge = 1'h1;
    else panel_reset = 1'h1;
    repeat (3) @(negedge clk);
    acknowledge = 1'h0;
    panel_reset = 1'h0;
  endtask : pulse
endmodule : pasc_field_model
`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench of the alarm sequence controller
// Assumes: short ack and investigation counts, 4 zones
// Notes: outputs are read 4 cycles after a pin change (sync 2 + reg 1, one to spare)
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pasc_pkg::*;
  localparam int ACK = 20;
  localparam int INV = 50;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic en, ack, prst, byp;
  logic [3:0] det_w, oth_w, zn;
  pasc_annunc_t an;
  pasc_state_t st;
  int fails = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  pasc_field_model #(.ZONES(4)) fm (.clk(clk), .sequence_enable(en),
    .detector_alarm(det_w), .other_initiating(oth_w), .acknowledge(ack),
    .panel_reset(prst), .sequence_bypass_input(byp));
  pasc_ctrl #(.ZONES(4), .ACK_CNT(ACK), .INV_CNT(INV)) uut (.clk(clk),
    .rst_n(rst_n), .sequence_enable(en), .detector_alarm(det_w),
    .other_initiating(oth_w), .acknowledge(ack), .panel_reset(prst),
    .sequence_bypass_input(byp), .zone_notify(zn), .annunc(an),
    .state(st));
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic see(input logic [1:0] s, input logic [3:0] z);
    cmp({6'h00, st}, {6'h00, s});
    cmp({4'h0, zn}, {4'h0, z});
  endtask : see
  task automatic det(input int z, input logic v);
    @(negedge clk);
    fm.set_det(z, v);
  endtask : det
  task automatic clear(input string name);
    @(negedge clk);
    fm.clear_field();
    fm.pulse(1);
    cyc(4);
    see(PASC_IDLE, 4'h0);
    $display("test %s done", name);
  endtask : clear
  task automatic give_verdict;
    $display("counts: %0d compares, %0d fails", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_ack;
    det(1, 1'h1);
    cyc(4);
    see(PASC_WAIT_ACK, 4'h0);
    cmp({5'h00, an}, 8'h06);
    fm.pulse(0);
    cyc(4);
    see(PASC_INVESTIGATE, 4'h0);
    clear("ack_then_reset");
    cmp({5'h00, an}, 8'h00);
  endtask : t_ack
  task automatic t_noack;
    det(2, 1'h1);
    cyc(ACK + 2);
    see(PASC_WAIT_ACK, 4'h0);
    cyc(1);
    see(PASC_NOTIFY, 4'h4);
    clear("no_ack");
  endtask : t_noack
  task automatic t_expire;
    det(0, 1'h1);
    cyc(4);
    fm.pulse(0);
    cyc(INV - 1);
    see(PASC_INVESTIGATE, 4'h0);
    cyc(1);
    see(PASC_NOTIFY, 4'h1);
    clear("expire");
  endtask : t_expire
  task automatic t_second;
    det(3, 1'h1);
    cyc(4);
    fm.pulse(0);
    cyc(4);
    det(0, 1'h1);
    cyc(2);
    see(PASC_INVESTIGATE, 4'h0);
    cyc(1);
    see(PASC_NOTIFY, 4'h8);
    clear("second_detector");
    det(1, 1'h1);
    cyc(4);
    fm.pulse(0);
    cyc(4);
    fm.set_oth(2, 1'h1);
    cyc(4);
    see(PASC_NOTIFY, 4'h6);
    clear("manual_station");
  endtask : t_second
  task automatic t_bypass;
    fm.set_bypass(1'h1);
    cyc(4);
    cmp({7'h00, an.trouble}, 8'h01);
    det(2, 1'h1);
    cyc(4);
    cmp({4'h0, zn}, 8'h04);
    fm.set_bypass(1'h0);
    cyc(4);
    cmp({7'h00, an.trouble}, 8'h00);
    clear("bypass");
    det(1, 1'h1);
    cyc(4);
    see(PASC_WAIT_ACK, 4'h0);
    clear("bypass_released");
  endtask : t_bypass
  task automatic t_disable;
    fm.set_enable(1'h0);
    det(0, 1'h1);
    cyc(4);
    cmp({4'h0, zn}, 8'h01);
    fm.set_enable(1'h1);
    clear("disabled");
  endtask : t_disable
  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    cyc(5);
    rst_n = 1'h1;
    cyc(1);
    see(PASC_IDLE, 4'h0);
    t_ack();
    t_noack();
    t_expire();
    t_second();
    t_bypass();
    t_disable();
    give_verdict();
  end
  // whole run is about 230 cycles; the 5000-cycle limit gives it about twenty times that
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
